/* bench/ofc_far_end.sv */
// Far side model: upstream chain unit, interlock switch and permit contact.
// Assumes the bench changes its commands just after a rising edge.
`timescale 1ns/1ps
module ofc_far_end (
  input  wire logic sys_clk,                 // Sampling clock
  input  wire logic up_fault,                // Upstream unit in fault
  input  wire logic door_open,               // Interlock switch open
  input  wire logic contact_open,            // Permit contact open
  output logic      chain_in = 1'b0,         // Upstream chain output
  output logic      interlock_in = 1'b0,     // Interlock pin, pulled up
  output logic      output_permit_in = 1'b0  // Permit pin, pulled up
);
  // Open contacts read high through the pull-ups
  always @(posedge sys_clk) begin
    chain_in         <= !up_fault;
    interlock_in     <= door_open;
    output_permit_in <= contact_open;
  end
  // recycling after protection trips is left to the controller
endmodule : ofc_far_end

/* bench/ofc_sva.sv */
// Port checker for the output permission and fault chain block.
// Assumes it is bound to ofc_top and sees only its ports.
`timescale 1ns/1ps
module ofc_chk
  import ofc_pkg::*;
#(
  parameter int unsigned TICK_DIV = 4,  // Cycles per tick
  parameter int unsigned N_FAULTS = 4   // Internal fault sources
) (
  input wire logic                sys_clk,           // Clock
  input wire logic                reset,             // Reset
  input wire logic                ce,                // Clock enable
  input wire logic                reg_rd,            // Read strobe
  input wire logic [DATA_W-1:0]   reg_rdata,         // Read data
  input wire logic [N_FAULTS-1:0] internal_fault_in, // Internal faults
  input wire logic                power_off_evt,     // Power switch off
  input wire logic                output_on_out,     // Output on
  input wire logic                chain_out,         // Chain output
  input wire logic                supply_good_oe,    // Supply good pull-down
  input wire logic                alarm_led_out,     // Alarm indicator
  input wire logic [MSG_W-1:0]    display_msg_out    // Display code
);
  // Slack covers tick phase at fault entry
  localparam int HOLD = BLINK_HALF_MS * TICK_DIV + 2 * TICK_DIV + 2;
  logic        alarm_q;
  int unsigned hold_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      alarm_q <= 1'b0;
      hold_q  <= 0;
    end else begin
      alarm_q <= alarm_led_out;
      hold_q  <= (chain_out || alarm_q != alarm_led_out) ? 0 : hold_q + 1;
    end
  end
  a_fault_off: assert property (ce && |internal_fault_in |=> !output_on_out && !chain_out)
    else $error("output or chain stayed up during internal fault");
  a_fault_msg: assert property (!chain_out |-> display_msg_out inside {[3'h2:3'h5]})
    else $error("fault without fault message");
  a_run_quiet: assert property (output_on_out && chain_out |-> display_msg_out == MSG_READINGS)
    else $error("readings not shown while running");
  a_alarm_dark: assert property (chain_out |-> !alarm_led_out)
    else $error("alarm lit without fault");
  a_sg_needs_on: assert property (supply_good_oe |-> output_on_out && chain_out)
    else $error("supply good while off or faulted");
  a_sg_drop: assert property ($fell(output_on_out) |-> !supply_good_oe)
    else $error("supply good late at turn-off");
  a_power_off: assert property (ce && power_off_evt |-> ##[1:2] !output_on_out)
    else $error("output kept on after power switch off");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read cycle");
  a_blink_hold: assert property (hold_q <= HOLD)
    else $error("alarm not blinking during fault");
  cover property ($rose(supply_good_oe));
  cover property ($rose(alarm_led_out));
  cover property (!chain_out ##1 chain_out);
endmodule : ofc_chk
bind ofc_top ofc_chk #(.TICK_DIV(TICK_DIV), .N_FAULTS(N_FAULTS)) ofc_chk_i (.sys_clk, .reset, .ce, .reg_rd,
  .reg_rdata, .internal_fault_in, .power_off_evt, .output_on_out, .chain_out, .supply_good_oe,
  .alarm_led_out, .display_msg_out);

/* bench/ofc_top_test.sv */
// Self-checking bench for the output permission and fault chain block.
// Assumes ofc_far_end drives the pins; ce stays high throughout.
`timescale 1ns/1ps
module ofc_top_test import ofc_pkg::*;;
  localparam int unsigned TDIV = 4;
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              chain_in, interlock_in, output_permit_in;
  logic [3:0]        fault = 4'h0;
  logic              pwr_off = 1'b0;
  logic              up_fault = 1'b1;
  logic              door_open = 1'b0;
  logic              contact_open = 1'b0;
  logic              out_on, chain_out, sg_oe, alarm;
  logic [MSG_W-1:0]  msg;
  logic [1:0]        aux_oe;
  int                fail_count = 0;
  int                cmp_count = 0;
  always #50 sys_clk = ~sys_clk;
  ofc_top #(.TICK_DIV(TDIV)) ofc_top_i (.sys_clk, .reset, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .chain_in, .interlock_in, .output_permit_in, .internal_fault_in(fault),
    .power_off_evt(pwr_off), .output_on_out(out_on), .chain_out, .supply_good_oe(sg_oe),
    .alarm_led_out(alarm), .display_msg_out(msg), .aux_oe);
  ofc_far_end ofc_far_end_i (.sys_clk, .up_fault, .door_open, .contact_open, .chain_in, .interlock_in,
    .output_permit_in);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask : rd
  task automatic wait_on(input logic e, input int n);
    #1;
    for (int i = 0; i < n && out_on !== e; i++) cyc(1);
    chk("output_on_out", e, out_on);
  endtask : wait_on
  task automatic st(input logic o, input logic c, input logic [2:0] m);
    chk("output_on_out", o, out_on);
    chk("chain_out", c, chain_out);
    chk("display_msg_out", m, msg);
  endtask : st
  task automatic t_reset;
    st(1'b0, 1'b1, MSG_OUT_OFF);
    chk("supply_good_oe", 1'b0, sg_oe);
    chk("aux_oe", 2'h3, aux_oe);
    rd(OFS_CTRL, 32'h0, "ctrl");
    rd(OFS_SGDELAY, 32'h0, "sgdelay");
    rd(8'h0c, 32'h0, "unmapped");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_aux;
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL, 32'(k) << CTRL_AUX1);
      cyc(2);
      chk("aux_oe", 32'(~k & 3), aux_oe);
    end
    $display("t_aux done");
  endtask : t_aux
  task automatic t_power;
    @(posedge sys_clk);
    door_open    <= 1'b1;
    contact_open <= 1'b1;
    wr(OFS_CTRL, 32'h03);
    wait_on(1'b1, 3);
    st(1'b1, 1'b1, MSG_READINGS);
    cyc(3);
    chk("supply_good_oe", 1'b1, sg_oe);
    $display("t_power done");
  endtask : t_power
  task automatic t_chain;
    wr(OFS_SGDELAY, 32'h5);
    @(posedge sys_clk);
    up_fault <= 1'b0;
    cyc(4);
    @(posedge sys_clk);
    up_fault <= 1'b1;
    wait_on(1'b0, 4);
    st(1'b0, 1'b0, MSG_SHUTOFF);
    chk("supply_good_oe", 1'b0, sg_oe);
    @(posedge sys_clk);
    up_fault <= 1'b0;
    wait_on(1'b1, 4);
    cyc(15);
    chk("supply_good_oe", 1'b0, sg_oe);
    for (int i = 0; i < 10 && sg_oe !== 1'b1; i++) cyc(1);
    chk("supply_good_oe", 1'b1, sg_oe);
    $display("t_chain done");
  endtask : t_chain
  task automatic t_ilk;
    int   tog;
    logic last;
    tog = 0;
    @(posedge sys_clk);
    door_open <= 1'b0;
    wr(OFS_CTRL, 32'h05);
    wait_on(1'b1, 3);
    @(posedge sys_clk);
    door_open <= 1'b1;
    wait_on(1'b0, 3);
    st(1'b0, 1'b0, MSG_INTERLOCK);
    last = alarm;
    repeat (9000) begin
      cyc(1);
      tog += int'(alarm !== last);
      last = alarm;
    end
    chk("alarm toggles", 1'b1, tog inside {2, 3});
    @(posedge sys_clk);
    door_open <= 1'b0;
    cyc(4);
    st(1'b0, 1'b1, MSG_OUT_OFF);
    rd(OFS_CTRL, 32'h04, "ctrl after trip");
    $display("t_ilk done");
  endtask : t_ilk
  task automatic t_permit;
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk);
      contact_open <= v[0];
      wr(OFS_CTRL, 32'h0b | (32'(v) << CTRL_PMT_INV));
      wait_on(1'b1, 3);
      @(posedge sys_clk);
      contact_open <= !v[0];
      wait_on(1'b0, 3);
      st(1'b0, 1'b0, MSG_PERMIT);
      @(posedge sys_clk);
      contact_open <= v[0];
      wait_on(1'b1, 4);
      st(1'b1, 1'b1, MSG_READINGS);
    end
    $display("t_permit done");
  endtask : t_permit
  task automatic t_fault;
    for (int b = 0; b < 4; b++) begin
      @(posedge sys_clk);
      fault <= 4'h1 << b;
      wait_on(1'b0, 3);
      st(1'b0, 1'b0, MSG_INTERNAL);
      @(posedge sys_clk);
      fault <= 4'h0;
      wait_on(1'b1, 4);
    end
    @(posedge sys_clk);
    pwr_off <= 1'b1;
    @(posedge sys_clk);
    pwr_off <= 1'b0;
    wait_on(1'b0, 3);
    rd(OFS_CTRL, 32'h1a, "ctrl after power off");
    rd(OFS_STATUS, 32'(MSG_OUT_OFF) << ST_MSG_LO, "status after power off");
    $display("t_fault done");
  endtask : t_fault
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    cyc(2);
    t_reset;
    t_aux;
    t_power;
    t_chain;
    t_ilk;
    t_permit;
    t_fault;
    finish_test;
  end
  // Tests need about 9200 cycles, most of them in the 9000-cycle blink watch
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    $display("[FAIL] watchdog expected done seen timeout");
    finish_test;
  end
endmodule : ofc_top_test

/* hw/ofc_tick.sv */
// Free-running divider that emits a one-cycle tick every DIV enabled clocks.
// Assumes the caller gates it with the shared clock enable.
`timescale 1ns/1ps
module ofc_tick #(
  parameter int unsigned DIV = 10000
) (
  input  wire logic sys_clk,  // System clock
  input  wire logic reset,    // Asynchronous reset, active high
  input  wire logic ce,       // Clock enable
  output logic      tick      // One-cycle pulse
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (ce) begin
      tick  <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end

endmodule : ofc_tick

/* hw/ofc_top.sv */
// Output permission and fault chaining logic of a programmable supply.
// Assumes all pin inputs are synchronous to sys_clk and already debounced.
//
// Functional notes
// R01: Internal fault drives chain output low, shows fault
// R02: Upstream chain fault turns output off, shutoff message
// R03: Recovery follows safe-start or auto-restart setting
// R04: Safe-start stays off; auto-restart resumes setting
// R05: Chain input armed by first falling edge
// R06: Auto-restart powers up on despite low chain
// R07: Chain input disarmed by off, power-off, faults
// R08: Armed chain level gates output, chain, supply-good
// R09: Interlock switchable; open input forces output off
// R10: Interlock trip: off, message, blinking alarm
// R11: Interlock clear: safe-start off, auto-restart resumes
// R12: Controller cycles interlock/permit after protection trips
// R13: Permit function switchable, default off
// R14: Permit polarity selects which level trips
// R15: Permit trip: off, message, blinking alarm
// R16: Permit clear: safe-start off, auto-restart resumes
// R17: Aux outputs: off pulls low, on releases
// R18: Supply-good released on fault or off
// R19: Delay postpones only supply-good turn-on edge
// R20: Output permitted only when no shutdown source
// R21: Normal running: alarm off, readings displayed
`timescale 1ns/1ps
module ofc_top
  import ofc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,  // Cycles per millisecond tick
  parameter int unsigned N_FAULTS = 4             // Number of internal fault sources
) (
  input  wire logic                sys_clk,          // System clock, 10 MHz
  input  wire logic                reset,            // Asynchronous reset, active high
  input  wire logic                ce,               // Clock enable, freezes state when low
  input  wire logic [ADDR_W-1:0]   reg_addr,         // Register byte address
  input  wire logic [DATA_W-1:0]   reg_wdata,        // Register write data
  input  wire logic                reg_wr,           // Write strobe
  input  wire logic                reg_rd,           // Read strobe
  output logic      [DATA_W-1:0]   reg_rdata,        // Read data, cycle after strobe
  input  wire logic                chain_in,         // Chain shutdown input, low is shutoff
  input  wire logic                interlock_in,     // Interlock input, high is open
  input  wire logic                output_permit_in, // Permit input level
  input  wire logic [N_FAULTS-1:0] internal_fault_in,// Internal fault levels, high is fault
  input  wire logic                power_off_evt,    // Power switch-off event pulse
  output logic                     output_on_out,    // Power stage enable
  output logic                     chain_out,        // Chain fault output, low on fault
  output logic                     supply_good_oe,   // Supply-good pull-down, high means pin low
  output logic                     alarm_led_out,    // Red alarm indicator
  output logic      [MSG_W-1:0]    display_msg_out,  // Display message code
  output logic      [1:0]          aux_oe            // Aux pull-downs, high means pin low
);

  ofc_regs_t q;
  ofc_regs_t d;
  logic      ms_tick;

  // Millisecond time base shared by blink and supply-good delay
  ofc_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .sys_clk (sys_clk),
    .reset   (reset),
    .ce      (ce),
    .tick    (ms_tick)
  );

  // Decoded register accesses
  logic wr_ctrl;
  logic wr_sgd;
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_sgd  = reg_wr && (reg_addr == OFS_SGDELAY);

  // Shutdown sources
  logic chain_fall;
  logic chain_trip;
  logic ilk_trip;
  logic pmt_trip;
  logic int_fault;
  logic other_fault;
  logic any_fault;
  logic off_cmd;
  logic sg_expired;

  // R05: falling edge of the chain input
  assign chain_fall = q.chain_prev && !chain_in;

  // R08: armed chain input low means shutoff
  assign chain_trip = q.armed && !chain_in;

  // R09: interlock open or high trips when enabled
  assign ilk_trip = q.ctrl[CTRL_ILK_EN] && interlock_in;

  // R13: permit level ignored while the function is off
  // R14: polarity flips which level trips
  assign pmt_trip = q.ctrl[CTRL_PMT_EN] && (output_permit_in ^ q.ctrl[CTRL_PMT_INV]);

  assign int_fault   = |internal_fault_in;
  assign other_fault = int_fault || ilk_trip || pmt_trip;

  // R20: any enabled source requests output off
  assign any_fault = other_fault || chain_trip;

  // Output-off command: software clears the on bit that was set
  assign off_cmd = wr_ctrl && q.ctrl[CTRL_OUT_ON] && !reg_wdata[CTRL_OUT_ON];

  assign sg_expired = (q.sg_cnt >= q.sg_delay);

  always_comb begin
    d = q;

    // Register writes
    if (wr_ctrl) begin
      d.ctrl = reg_wdata[CTRL_W-1:0];
    end
    if (wr_sgd) begin
      d.sg_delay = reg_wdata[SGD_W-1:0];
    end

    // Chain arming; the disarm events outrank a coincident edge
    d.chain_prev = chain_in;
    // R07: off command, power switch-off and faults disarm
    if (off_cmd || power_off_evt || other_fault) begin
      d.armed = 1'b0;
    // R05: arm only after a falling edge
    end else if (chain_fall) begin
      d.armed = 1'b1;
    end

    // Power switch-off also drops the stored on setting
    if (power_off_evt) begin
      d.ctrl[CTRL_OUT_ON] = 1'b0;
    end

    // Output state machine
    case (q.st)
      S_OFF: begin
        // R06: at power-up the chain is unarmed, so a low level cannot block
        if (d.ctrl[CTRL_OUT_ON] && !any_fault) begin
          d.st = S_ON;
        end
      end
      S_ON: begin
        // R02: chain trip shuts the output off
        if (any_fault) begin
          d.st = S_FAULT;
          // R04: safe-start forgets the on setting
          if (!q.ctrl[CTRL_AUTO] && !wr_ctrl) begin
            d.ctrl[CTRL_OUT_ON] = 1'b0;
          end
        end else if (!d.ctrl[CTRL_OUT_ON]) begin
          d.st = S_OFF;
        end
      end
      S_FAULT: begin
        // R03: recover according to start mode
        // R11: interlock clear follows the same path
        // R16: permit clear follows the same path
        if (!any_fault) begin
          d.st = d.ctrl[CTRL_OUT_ON] ? S_ON : S_OFF;
        end
      end
      default: begin
        d.st = S_OFF;
      end
    endcase

    // R19: delay counts only while the output is on and clean
    if (q.st != S_ON || any_fault) begin
      d.sg_cnt = '0;
    end else if (ms_tick && !sg_expired) begin
      d.sg_cnt = q.sg_cnt + 1'b1;
    end

    // Blink phase runs freely; a fixed phase keeps chained units in step visually
    if (ms_tick) begin
      if (q.blink_cnt == BLINK_LAST) begin
        d.blink_cnt = '0;
        d.blink     = !q.blink;
      end else begin
        d.blink_cnt = q.blink_cnt + 1'b1;
      end
    end

    // Registered outputs
    d.out_on = (d.st == S_ON);

    // R01: internal fault pulls the chain line low
    // R08: chain trip also propagates downstream
    d.chain_out = !any_fault;

    // R18: released on fault or off
    // R19: pull-down waits for the delay; release is immediate
    // Next state used so the release lands with the output turn-off edge
    d.sg_oe = (d.st == S_ON) && !any_fault && sg_expired;

    // R10: interlock trip blinks the alarm
    // R15: permit trip blinks the alarm
    // R21: alarm dark with no fault
    d.alarm = any_fault && q.blink;

    // R01: internal fault message has top priority
    // R02: shutoff message for chain trip
    // R10: interlock message
    // R15: permit message
    // R21: readings while running normally
    if (int_fault) begin
      d.msg = MSG_INTERNAL;
    end else if (chain_trip) begin
      d.msg = MSG_SHUTOFF;
    end else if (ilk_trip) begin
      d.msg = MSG_INTERLOCK;
    end else if (pmt_trip) begin
      d.msg = MSG_PERMIT;
    end else if (d.st == S_ON) begin
      d.msg = MSG_READINGS;
    end else begin
      d.msg = MSG_OUT_OFF;
    end

    // R17: setting off pulls the pin low, on releases it
    d.aux_oe[0] = !d.ctrl[CTRL_AUX1];
    d.aux_oe[1] = !d.ctrl[CTRL_AUX2];

    // Read data stands only in the cycle after the strobe
    d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: begin
          d.rdata[CTRL_W-1:0] = q.ctrl;
        end
        OFS_SGDELAY: begin
          d.rdata[SGD_W-1:0] = q.sg_delay;
        end
        OFS_STATUS: begin
          d.rdata[ST_OUT_ON]                   = q.out_on;
          d.rdata[ST_ARMED]                    = q.armed;
          d.rdata[ST_CHAIN]                    = chain_trip;
          d.rdata[ST_ILK]                      = ilk_trip;
          d.rdata[ST_PMT]                      = pmt_trip;
          d.rdata[ST_INTERNAL]                 = int_fault;
          d.rdata[ST_SG_GOOD]                  = q.sg_oe;
          d.rdata[ST_MSG_LO+MSG_W-1:ST_MSG_LO] = q.msg;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q.st         <= S_OFF;
      q.ctrl       <= CTRL_RST;
      q.sg_delay   <= SGD_RST;
      q.sg_cnt     <= '0;
      q.chain_prev <= 1'b0;
      q.armed      <= 1'b0;
      q.blink_cnt  <= '0;
      q.blink      <= 1'b0;
      q.rdata      <= '0;
      q.out_on     <= 1'b0;
      q.chain_out  <= 1'b1;
      q.sg_oe      <= 1'b0;
      q.alarm      <= 1'b0;
      q.msg        <= MSG_OUT_OFF;
      q.aux_oe     <= 2'h3;
    end else if (ce) begin
      q <= d;
    end
  end

  assign reg_rdata       = q.rdata;
  assign output_on_out   = q.out_on;
  assign chain_out       = q.chain_out;
  assign supply_good_oe  = q.sg_oe;
  assign alarm_led_out   = q.alarm;
  assign display_msg_out = q.msg;
  assign aux_oe          = q.aux_oe;

endmodule : ofc_top

/* shared/ofc_pkg.sv */
// Constants, register map and state types for the output permission and fault chain block.
// Assumes a single 10 MHz system clock and a simple strobed register port.
package ofc_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TICK_TIME_MS    = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_TIME_MS;
  // Alarm blink at 1/2 Hz: full period in milliseconds, toggled every half period
  localparam int unsigned BLINK_PERIOD_MS = 2000;
  localparam int unsigned BLINK_HALF_MS   = BLINK_PERIOD_MS / 2;
  localparam int unsigned BLINK_W         = 10;
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF_MS - 1);

  // Register port
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SGDELAY = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_W        = 7;
  localparam int unsigned CTRL_OUT_ON   = 0;
  localparam int unsigned CTRL_AUTO     = 1;
  localparam int unsigned CTRL_ILK_EN   = 2;
  localparam int unsigned CTRL_PMT_EN   = 3;
  localparam int unsigned CTRL_PMT_INV  = 4;
  localparam int unsigned CTRL_AUX1     = 5;
  localparam int unsigned CTRL_AUX2     = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  // Supply-good delay register, in milliseconds
  localparam int unsigned SGD_W = 16;
  localparam logic [SGD_W-1:0] SGD_RST = 16'h0000;

  // Status register fields
  localparam int unsigned ST_OUT_ON   = 0;
  localparam int unsigned ST_ARMED    = 1;
  localparam int unsigned ST_CHAIN    = 2;
  localparam int unsigned ST_ILK      = 3;
  localparam int unsigned ST_PMT      = 4;
  localparam int unsigned ST_INTERNAL = 5;
  localparam int unsigned ST_SG_GOOD  = 6;
  localparam int unsigned ST_MSG_LO   = 8;

  // Display message codes
  localparam int unsigned MSG_W = 3;
  typedef enum logic [MSG_W-1:0] {
    MSG_READINGS  = 3'h0,
    MSG_OUT_OFF   = 3'h1,
    MSG_INTERNAL  = 3'h2,
    MSG_SHUTOFF   = 3'h3,
    MSG_INTERLOCK = 3'h4,
    MSG_PERMIT    = 3'h5
  } ofc_msg_t;

  // Output state machine, one-hot
  typedef enum logic [2:0] {
    S_OFF   = 3'h1,
    S_ON    = 3'h2,
    S_FAULT = 3'h4
  } ofc_state_t;

  typedef struct packed {
    ofc_state_t         st;
    logic [CTRL_W-1:0]  ctrl;
    logic [SGD_W-1:0]   sg_delay;
    logic [SGD_W-1:0]   sg_cnt;
    logic               chain_prev;
    logic               armed;
    logic [BLINK_W-1:0] blink_cnt;
    logic               blink;
    logic [DATA_W-1:0]  rdata;
    logic               out_on;
    logic               chain_out;
    logic               sg_oe;
    logic               alarm;
    ofc_msg_t           msg;
    logic [1:0]         aux_oe;
  } ofc_regs_t;

endpackage : ofc_pkg
